/* logic/art_timer.sv */
// 16-bit up-counting auto-reload timer with its three special
// function registers; assumes a single-cycle register port from the
// core, synchronous to CLK, and an interrupt controller that pulses
// ISR_ENTER when the timer vector is taken
`timescale 1ns/1ps

// Notes on behaviour
// - sixteen-bit counter, counts up only, refilled from a reload value
// - three-bit prescale: 000 divides by 1, each step doubles, 111 by 128
// - counter advances only while run bit is 1, holds while 0
// - rollover from ffff sets the overflow flag
// - every rollover loads counter with high and low reload bytes
// - flag set and interrupt enable high requests timer service
// - entering the timer service routine clears the overflow flag
// - software writes may set or clear the overflow flag directly
// - control: flag bit 4, run bit 3, prescale bits 2:0
// - overflow offered as baud clock source to both serial ports
// - reload low register holds bits 7:0 of the reload value
// - separate read-write reload high register holds upper eight bits
module art_timer (
    // system
    input  wire logic        CLK,
    input  wire logic        NRST,
    // special function register port
    input  wire logic [7:0]  SFR_ADDR,
    input  wire logic        SFR_WR,
    input  wire logic [7:0]  SFR_WDATA,
    output logic      [7:0]  SFR_RDATA,
    // interrupt controller
    input  wire logic        OVF_IRQ_EN,
    input  wire logic        ISR_ENTER,
    output logic             IRQ_REQ,
    // serial ports
    output logic             BAUD_TICK
);
    // registers
    logic [art_pkg::CNT_W-1:0]  cnt_q;
    logic [art_pkg::CNT_W-1:0]  cnt_d;
    logic                       ovf_q;
    logic                       ovf_d;
    logic                       run_q;
    logic [art_pkg::PS_W-1:0]   ps_q;
    logic [art_pkg::UART_W-1:0] uart_q;
    logic [art_pkg::DATA_W-1:0] rld_lo_q;
    logic [art_pkg::DATA_W-1:0] rld_hi_q;
    logic [art_pkg::DATA_W-1:0] rdata_q;
    logic [art_pkg::DATA_W-1:0] rdata_d;
    logic                       irq_q;
    logic                       baud_q;

    // decode
    logic                       wr_ctrl;
    logic                       wr_lo;
    logic                       wr_hi;
    logic                       rd_ctrl;
    logic                       rd_lo;
    logic                       rd_hi;
    logic                       step;
    logic                       wrap;
    logic [art_pkg::CNT_W-1:0]  reload;
    logic [art_pkg::DATA_W-1:0] ctrl_view;
    logic                       ovf_after_clr;

    art_tick_if tk ();

    art_prescaler u_presc (
        .CLK  (CLK),
        .NRST (NRST),
        .tk   (tk.presc)
    );

    assign tk.run     = run_q;
    assign tk.div_sel = ps_q;

    assign rd_ctrl = (SFR_ADDR == art_pkg::ADDR_CTRL);
    assign rd_lo   = (SFR_ADDR == art_pkg::ADDR_RLD_LO);
    assign rd_hi   = (SFR_ADDR == art_pkg::ADDR_RLD_HI);
    assign wr_ctrl = SFR_WR && rd_ctrl;
    // reload writes are not blocked while running; software must halt
    // first, otherwise a wrap may pick up a half-written value
    assign wr_lo   = SFR_WR && rd_lo;
    assign wr_hi   = SFR_WR && rd_hi;

    // count only on a prescaled tick while running
    assign step   = tk.tick && run_q;
    assign wrap   = step && (cnt_q == art_pkg::CNT_TOP);
    assign reload = {rld_hi_q, rld_lo_q};

    // up only, refilled from reload on wrap
    assign cnt_d = wrap ? reload
                 : step ? cnt_q + art_pkg::CNT_STEP
                 : cnt_q;

    // software value or service entry clears, but a wrap in the same
    // cycle wins so no overflow is lost
    assign ovf_after_clr = wr_ctrl ? SFR_WDATA[art_pkg::BIT_OVF]
                         : ISR_ENTER ? 1'b0
                         : ovf_q;
    assign ovf_d = wrap || ovf_after_clr;

    // control layout
    assign ctrl_view = {uart_q, ovf_q, run_q, ps_q};

    assign rdata_d = rd_ctrl ? ctrl_view
                   : rd_lo   ? rld_lo_q
                   : rd_hi   ? rld_hi_q
                   : art_pkg::RD_UNMAPPED;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cnt_q <= art_pkg::CNT_RST;
            ovf_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            ovf_q <= ovf_d;
        end
    end

    // control register; bits 7:5 are serial-port mode bits kept here
    // as plain storage because they share the address
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            run_q  <= art_pkg::CTRL_RST[art_pkg::BIT_RUN];
            ps_q   <= art_pkg::CTRL_RST[art_pkg::PS_LSB +: art_pkg::PS_W];
            uart_q <= art_pkg::CTRL_RST[art_pkg::UART_LSB +: art_pkg::UART_W];
        end else if (wr_ctrl) begin
            run_q  <= SFR_WDATA[art_pkg::BIT_RUN];
            ps_q   <= SFR_WDATA[art_pkg::PS_LSB +: art_pkg::PS_W];
            uart_q <= SFR_WDATA[art_pkg::UART_LSB +: art_pkg::UART_W];
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rld_lo_q <= art_pkg::RLD_RST;
        end else if (wr_lo) begin
            rld_lo_q <= SFR_WDATA;
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rld_hi_q <= art_pkg::RLD_RST;
        end else if (wr_hi) begin
            rld_hi_q <= SFR_WDATA;
        end
    end

    // outputs all registered; irq follows the flag one cycle later
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rdata_q <= art_pkg::RD_UNMAPPED;
            irq_q   <= 1'b0;
            baud_q  <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            irq_q   <= ovf_q && OVF_IRQ_EN;
            baud_q  <= wrap;
        end
    end

    assign SFR_RDATA = rdata_q;
    assign IRQ_REQ   = irq_q;
    assign BAUD_TICK = baud_q;
endmodule : art_timer

/* shared/art_pkg.sv */
// constants for the 16-bit auto-reload timer: register map, field
// positions, widths and reset values shared by its modules
package art_pkg;
    // special function register addresses
    localparam logic [7:0]  ADDR_CTRL    = 8'hc4;
    localparam logic [7:0]  ADDR_RLD_LO  = 8'hc5;
    localparam logic [7:0]  ADDR_RLD_HI  = 8'hc6;
    // control register fields
    localparam int          BIT_OVF      = 4;
    localparam int          BIT_RUN      = 3;
    localparam int          PS_LSB       = 0;
    localparam int          PS_W         = 3;
    localparam int          UART_LSB     = 5;
    localparam int          UART_W       = 3;
    // widths
    localparam int          DATA_W       = 8;
    localparam int          CNT_W        = 16;
    localparam int          PRE_W        = 7;
    // reset values and counter constants
    localparam logic [7:0]  CTRL_RST     = 8'h00;
    localparam logic [7:0]  RLD_RST      = 8'h00;
    localparam logic [15:0] CNT_RST      = 16'h0000;
    localparam logic [15:0] CNT_TOP      = 16'hffff;
    localparam logic [15:0] CNT_STEP     = 16'h0001;
    localparam logic [6:0]  PRE_RST      = 7'h00;
    localparam logic [6:0]  PRE_STEP     = 7'h01;
    localparam logic [7:0]  DIV_ONE      = 8'h01;
    localparam logic [7:0]  RD_UNMAPPED  = 8'h00;
endpackage : art_pkg

/* shared/art_tick_if.sv */
// carrier between the timer core and its clock prescaler
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
interface art_tick_if;
    logic                        run;
    logic [art_pkg::PS_W-1:0]    div_sel;
    logic                        tick;

    modport core  (output run, output div_sel, input  tick);
    modport presc (input  run, input  div_sel, output tick);
endinterface : art_tick_if

/* logic/art_prescaler.sv */
// count clock prescaler: one tick every 2**div_sel system clocks
// assumes run and div_sel come from flops in the same clock domain
`timescale 1ns/1ps
module art_prescaler (
    // system
    input  wire logic  CLK,
    input  wire logic  NRST,
    // to timer core
    art_tick_if.presc  tk
);
    logic [art_pkg::PRE_W-1:0] pre_q;
    logic [art_pkg::PRE_W-1:0] pre_d;
    logic [7:0]                span;
    logic [7:0]                mask_full;
    logic [art_pkg::PRE_W-1:0] mask;

    // divisor doubles per select step, 1/1 up to 1/128
    assign span      = art_pkg::DIV_ONE << tk.div_sel;
    assign mask_full = span - art_pkg::DIV_ONE;
    assign mask      = mask_full[art_pkg::PRE_W-1:0];
    assign tk.tick   = tk.run && ((pre_q & mask) == mask);

    // held at zero while halted so every start has the same phase
    assign pre_d = tk.run ? pre_q + art_pkg::PRE_STEP : art_pkg::PRE_RST;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            pre_q <= art_pkg::PRE_RST;
        end else begin
            pre_q <= pre_d;
        end
    end
endmodule : art_prescaler

/* tb/art_chk.sv */
// port checker for the auto-reload timer
// assumes the flag, irq and read latencies of the register port
`timescale 1ns/1ps
module art_chk (
    // system
    input wire logic       CLK,
    input wire logic       NRST,
    // register port
    input wire logic [7:0] SFR_ADDR,
    input wire logic       SFR_WR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic [7:0] SFR_RDATA,
    // irq and baud
    input wire logic       OVF_IRQ_EN,
    input wire logic       ISR_ENTER,
    input wire logic       IRQ_REQ,
    input wire logic       BAUD_TICK
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);
    wire ctl_wr = SFR_WR && SFR_ADDR == art_pkg::ADDR_CTRL;
    wire lo_sel = SFR_ADDR == art_pkg::ADDR_RLD_LO;
    irq_gate_a: assert property (!OVF_IRQ_EN |=> !IRQ_REQ)
        else $error("irq without enable");
    // flag is set on the edge that raises the baud pulse, irq one later
    wrap_irq_a: assert property (BAUD_TICK && OVF_IRQ_EN |=> IRQ_REQ)
        else $error("wrap gave no irq");
    // a wrap in the clear cycle shows as a baud pulse one cycle earlier
    isr_clear_a: assert property (ISR_ENTER && !ctl_wr |-> ##2 (!IRQ_REQ || $past(BAUD_TICK)))
        else $error("flag kept after isr");
    sw_clear_a: assert property (ctl_wr && !SFR_WDATA[4] |-> ##2 (!IRQ_REQ || $past(BAUD_TICK)))
        else $error("flag kept after clear");
    sw_set_a: assert property (ctl_wr && SFR_WDATA[4] ##1 OVF_IRQ_EN |=> IRQ_REQ)
        else $error("flag not set by write");
    halt_hold_a: assert property (ctl_wr && !SFR_WDATA[3] ##1 !SFR_WR [*3] |=> !BAUD_TICK)
        else $error("wrap while halted");
    rd_lat_a: assert property (SFR_WR && lo_sel ##1 lo_sel && !SFR_WR |=> SFR_RDATA == $past(SFR_WDATA, 2))
        else $error("reload low readback");
    unmapped_rd_a: assert property (!(SFR_ADDR inside {8'hc4, 8'hc5, 8'hc6}) |=> SFR_RDATA == 8'h00)
        else $error("unmapped read not zero");
    cover property (BAUD_TICK && IRQ_REQ);
    cover property (ISR_ENTER && IRQ_REQ);
    cover property (ctl_wr && SFR_WDATA[3]);
endmodule : art_chk

bind art_timer art_chk u_chk (.CLK, .NRST, .SFR_ADDR, .SFR_WR, .SFR_WDATA,
    .SFR_RDATA, .OVF_IRQ_EN, .ISR_ENTER, .IRQ_REQ, .BAUD_TICK);

/* tb/art_timer_tb_top.sv */
// testbench for the auto-reload timer, driven through its register port
// assumes the checker is bound in; inputs move 1 ns after the rising edge
`timescale 1ns/1ps
module art_timer_tb_top;
    logic       CLK = 1'b0;
    logic       NRST = 1'b0;
    logic [7:0] SFR_ADDR = 8'h00;
    logic       SFR_WR = 1'b0;
    logic [7:0] SFR_WDATA = 8'h00;
    logic [7:0] SFR_RDATA;
    logic       OVF_IRQ_EN = 1'b0;
    logic       ISR_ENTER = 1'b0;
    logic       IRQ_REQ;
    logic       BAUD_TICK;
    int         bad_count = 0;
    int         checks = 0;
    int         n;
    always #10 CLK = ~CLK;
    art_timer dut (.CLK, .NRST, .SFR_ADDR, .SFR_WR, .SFR_WDATA, .SFR_RDATA,
                   .OVF_IRQ_EN, .ISR_ENTER, .IRQ_REQ, .BAUD_TICK);
    task automatic results;
        if (bad_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        SFR_ADDR = a;
        SFR_WDATA = d;
        SFR_WR = 1'b1;
        @(posedge CLK);
        #1 SFR_WR = 1'b0;
        // idle edge so a following write never re-raises the strobe at once
        @(posedge CLK);
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        SFR_ADDR = a;
        @(posedge CLK);
        #1 chk(SFR_RDATA, e);
    endtask : rd
    // third pulse only: the first may still follow the old settings
    task automatic period(input int exp);
        repeat (3) begin
            n = 0;
            do begin
                @(posedge CLK);
                #1 n++;
            end while (BAUD_TICK !== 1'b1 && n < 70000);
            if (BAUD_TICK !== 1'b1) begin
                bad_count++;
                results();
            end
        end
        chk(n, exp);
    endtask : period
    initial begin
        repeat (16) @(posedge CLK);
        #1 NRST = 1'b1;
        rd(8'hc4, 8'h00);
        rd(8'hc5, 8'h00);
        rd(8'hc6, 8'h00);
        rd(8'hc7, 8'h00);
        wr(8'hc5, 8'ha5);
        rd(8'hc5, 8'ha5);
        wr(8'hc6, 8'h5a);
        rd(8'hc6, 8'h5a);
        wr(8'hc4, 8'he7);
        rd(8'hc4, 8'he7);
        wr(8'hc5, 8'hfe);
        wr(8'hc6, 8'hff);
        OVF_IRQ_EN = 1'b1;
        for (int s = 0; s < 8; s++) begin
            wr(8'hc4, 8'h08 | 8'(s));
            period(2 << s);
        end
        rd(8'hc4, 8'h1f);
        wr(8'hc4, 8'h00);
        rd(8'hc4, 8'h00);
        repeat (100) begin
            @(posedge CLK);
            #1 chk(BAUD_TICK, 1'b0);
        end
        wr(8'hc5, 8'h00);
        wr(8'hc6, 8'hfe);
        wr(8'hc4, 8'h08);
        period(512);
        wr(8'hc4, 8'h10);
        @(posedge CLK);
        #1 chk(IRQ_REQ, 1'b1);
        ISR_ENTER = 1'b1;
        @(posedge CLK);
        #1 ISR_ENTER = 1'b0;
        @(posedge CLK);
        #1 chk(IRQ_REQ, 1'b0);
        rd(8'hc4, 8'h00);
        wr(8'hc4, 8'h10);
        OVF_IRQ_EN = 1'b0;
        @(posedge CLK);
        #1 chk(IRQ_REQ, 1'b0);
        results();
    end
endmodule : art_timer_tb_top
